// >>> common/spss_pkg.sv
package spss_pkg;

  // Register offsets, byte addresses
  localparam logic [15:0] OFS_OWNERSHIP = 16'h0980;
  localparam logic [15:0] OFS_ACTIVATION = 16'h0981;
  localparam logic [15:0] OFS_PULSE_WIDTH = 16'h0982;
  localparam logic [15:0] OFS_ACT_STATE = 16'h0984;
  localparam logic [15:0] OFS_FIRST_ACK = 16'h098E;
  localparam logic [15:0] OFS_SECOND_ACK = 16'h098F;
  localparam logic [15:0] OFS_START_TIME = 16'h0990;
  localparam logic [15:0] OFS_NEXT_SECOND = 16'h0998;
  localparam logic [15:0] OFS_FIRST_PERIOD = 16'h09A0;

  // Activation control bit positions
  localparam int unsigned ACT_ENABLE = 0;
  localparam int unsigned ACT_GEN_FIRST = 1;
  localparam int unsigned ACT_GEN_SECOND = 2;
  localparam int unsigned ACT_AUTO = 3;
  localparam int unsigned ACT_EXTEND = 4;
  localparam int unsigned ACT_PLAUS = 5;
  localparam int unsigned ACT_NEAR_SHORT = 6;
  localparam int unsigned ACT_DEBUG = 7;

  // Activation status bit positions
  localparam int unsigned ST_FIRST_PENDING = 0;
  localparam int unsigned ST_SECOND_PENDING = 1;
  localparam int unsigned ST_PLAUS_OUT = 2;

  // Acknowledge state and ownership bit positions
  localparam int unsigned ACK_STATE_BIT = 0;
  localparam int unsigned OWN_HOST_BIT = 0;

  // Reset values
  localparam logic [7:0] ACT_RESET = 8'h00;
  localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;

  // System time is 64 bits wide in this build
  localparam logic WIDE_TIME = 1'b1;

  // Near-future windows
  localparam logic [63:0] NEAR_LONG = 64'h8000_0000_0000_0000;
  localparam logic [63:0] NEAR_SHORT = 64'h0000_0000_8000_0000;

  // Timing
  localparam int unsigned PULSE_UNIT_NS = 10;
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Access sides
  localparam int unsigned SIDE_NET = 0;
  localparam int unsigned SIDE_HOST = 1;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_TIMED = 2'b01,
    OUT_HELD = 2'b10
  } spss_out_t;

endpackage

// >>> rtl/spss_snapshot.sv
`timescale 1ns/10ps
`default_nettype none
module spss_snapshot
  import spss_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic rd, // Read strobe of this side
  input wire logic [15:0] addr, // Byte address of this side
  input wire logic [63:0] start_live, // Live next first pulse time
  input wire logic [63:0] second_live, // Live next second pulse time
  output logic [55:0] start_snap, // Held bits 63:8 of start register
  output logic [55:0] second_snap // Held bits 63:8 of second register
);

  typedef struct packed {
    logic [55:0] start_hi;
    logic [55:0] second_hi;
  } spss_snap_t;

  spss_snap_t s;
  spss_snap_t next_s;

  always_comb
  begin
    next_s = s;
    if (rd && addr == OFS_START_TIME)
    begin
      next_s.start_hi = start_live[63:8];
    end
    if (rd && addr == OFS_NEXT_SECOND)
    begin
      next_s.second_hi = second_live[63:8];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign start_snap = s.start_hi;
  assign second_snap = s.second_hi;

endmodule // spss_snapshot
`default_nettype wire

// >>> rtl/spss_sync_schedule.sv
// Overview of operation
// - Status bit 0: first channel first pulse pending
// - Status bit 1: second channel first pulse pending
// - Status bit 2: start time outside near future
// - Ack state bit follows output; host ack clears
// - Read-ack mode: host read clears event request
// - Write-ack mode: host write clears, data ignored
// - Start write loads time; read gives next pulse
// - Low byte read snapshots upper bits per side
// - Start writes accepted from owning side only
// - Start time adopted on activation rising edge
// - Auto-activation sets enable after start write
// - Lower-only write extended to 64 bits
// - Read-only next second pulse time register
// - First pulses spaced by cycle time in ns
// - Zero cycle time gives single shot
// - Start register 32 or 64 bits wide
// - Width in 10 ns units; zero holds output
// - Scheduling runs only while unit enabled
`timescale 1ns/10ps
`default_nettype none
module spss_sync_schedule
  import spss_pkg::*;
(
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [15:0] net_addr, // Network side byte address
  input wire logic net_rd, // Network side read strobe
  input wire logic net_wr, // Network side write strobe
  input wire logic [7:0] net_wdata, // Network side write byte
  output logic [7:0] net_rdata, // Network side read byte
  input wire logic [15:0] host_addr, // Host port byte address
  input wire logic host_rd, // Host port read strobe
  input wire logic host_wr, // Host port write strobe
  input wire logic [7:0] host_wdata, // Host port write byte
  output logic [7:0] host_rdata, // Host port read byte
  input wire logic frame_end, // End of network frame pulse
  input wire logic [63:0] system_time, // System time in ns
  input wire logic [15:0] pulse_width, // Pulse width, 10 ns units
  input wire logic ack_by_write, // Host acknowledges by write
  input wire logic [63:0] next_second_time, // Next second pulse time
  input wire logic second_pending, // Second first pulse pending
  input wire logic second_sync_pulse, // Second channel output level
  output logic first_sync_pulse, // First channel output
  output logic [1:0] app_event_request, // Event requests, first/second
  output logic second_ack_clear, // Clears held second output
  output logic unit_active, // Unit enable bit
  output logic second_gen_enable // Second channel generation
);

  typedef struct packed {
    logic owner_host;
    logic [7:0] act;
    logic [63:0] start_stage;
    logic start_pending;
    logic upper_written;
    logic [63:0] next_first;
    logic [31:0] period;
    logic first_pending;
    logic plaus_out;
    logic single_done;
    spss_out_t out_state;
    logic first_out;
    logic [16:0] pulse_cnt;
    logic [1:0] event_req;
    logic second_prev;
    logic second_ack_clear;
    logic [1:0][7:0] rdata;
  } spss_state_t;

  spss_state_t s;
  spss_state_t next_s;

  logic [15:0] addr_a [2];
  logic rd_a [2];
  logic wr_a [2];
  logic [7:0] wdata_a [2];
  logic [55:0] snap_start [2];
  logic [55:0] snap_second [2];
  logic owner_ok [2];

  assign addr_a[SIDE_NET] = net_addr;
  assign addr_a[SIDE_HOST] = host_addr;
  assign rd_a[SIDE_NET] = net_rd;
  assign rd_a[SIDE_HOST] = host_rd;
  assign wr_a[SIDE_NET] = net_wr;
  assign wr_a[SIDE_HOST] = host_wr;
  assign wdata_a[SIDE_NET] = net_wdata;
  assign wdata_a[SIDE_HOST] = host_wdata;
  assign owner_ok[SIDE_NET] = !s.owner_host;
  assign owner_ok[SIDE_HOST] = s.owner_host;

  // Eight-byte register window hit
  function automatic logic hit8(input logic [15:0] a, input logic [15:0] b);
    return a[15:3] == b[15:3];
  endfunction

  // Four-byte register window hit
  function automatic logic hit4(input logic [15:0] a, input logic [15:0] b);
    return a[15:2] == b[15:2];
  endfunction

  // Upper half of a 64-bit window absent in 32-bit builds
  function automatic logic lane_ok(input logic [15:0] a);
    return WIDE_TIME || !a[2];
  endfunction

  // Pulse width in 10 ns units to clock cycles, rounded up
  function automatic logic [16:0] width_cycles(input logic [15:0] w);
    logic [31:0] ns;
    ns = 32'(w) * PULSE_UNIT_NS + (CLK_PERIOD_NS - 1);
    return 17'(ns / CLK_PERIOD_NS);
  endfunction

  spss_snapshot u_snap_net (
    .clk(clk),
    .rst(rst),
    .rd(net_rd),
    .addr(net_addr),
    .start_live(s.next_first),
    .second_live(next_second_time),
    .start_snap(snap_start[SIDE_NET]),
    .second_snap(snap_second[SIDE_NET])
  );

  spss_snapshot u_snap_host (
    .clk(clk),
    .rst(rst),
    .rd(host_rd),
    .addr(host_addr),
    .start_live(s.next_first),
    .second_live(next_second_time),
    .start_snap(snap_start[SIDE_HOST]),
    .second_snap(snap_second[SIDE_HOST])
  );

  always_comb
  begin
    logic adopt;
    logic act_wr;
    logic [7:0] act_new;
    logic [1:0] start_hit;
    logic commit;
    logic debug_fire;
    logic immediate;
    logic reached;
    logic fire;
    logic [63:0] diff;
    logic [63:0] full;
    logic [7:0] rb;
    adopt = 1'b0;
    act_wr = 1'b0;
    act_new = s.act;
    start_hit = 2'b00;
    commit = 1'b0;
    debug_fire = 1'b0;
    immediate = 1'b0;
    reached = 1'b0;
    fire = 1'b0;
    diff = '0;
    full = '0;
    rb = 8'h00;
    next_s = s;
    next_s.second_ack_clear = 1'b0;

    for (int i = 0; i < 2; i++)
    begin
      // Register writes
      if (wr_a[i] && i == SIDE_NET && addr_a[i] == OFS_OWNERSHIP)
      begin
        next_s.owner_host = wdata_a[i][OWN_HOST_BIT];
      end
      if (wr_a[i] && owner_ok[i])
      begin
        if (addr_a[i] == OFS_ACTIVATION)
        begin
          act_wr = 1'b1;
          act_new = wdata_a[i];
        end
        if (hit8(addr_a[i], OFS_START_TIME) && lane_ok(addr_a[i]))
        begin
          next_s.start_stage[{addr_a[i][2:0], 3'b000} +: 8] = wdata_a[i];
          start_hit[i] = 1'b1;
          if (addr_a[i][2])
          begin
            next_s.upper_written = 1'b1;
          end
        end
        if (hit4(addr_a[i], OFS_FIRST_PERIOD))
        begin
          next_s.period[{addr_a[i][1:0], 3'b000} +: 8] = wdata_a[i];
        end
      end

      // Register reads, answered one cycle after the strobe
      rb = 8'h00;
      if (addr_a[i] == OFS_OWNERSHIP)
      begin
        rb = {7'h00, s.owner_host};
      end
      else if (addr_a[i] == OFS_ACTIVATION)
      begin
        rb = s.act;
      end
      else if (addr_a[i] == OFS_PULSE_WIDTH)
      begin
        rb = pulse_width[7:0];
      end
      else if (addr_a[i] == OFS_PULSE_WIDTH + 16'h0001)
      begin
        rb = pulse_width[15:8];
      end
      else if (addr_a[i] == OFS_ACT_STATE)
      begin
        rb[ST_FIRST_PENDING] = s.first_pending;
        rb[ST_SECOND_PENDING] = second_pending;
        rb[ST_PLAUS_OUT] = s.plaus_out;
      end
      else if (addr_a[i] == OFS_FIRST_ACK)
      begin
        rb[ACK_STATE_BIT] = s.first_out;
      end
      else if (addr_a[i] == OFS_SECOND_ACK)
      begin
        rb[ACK_STATE_BIT] = second_sync_pulse;
      end
      else if (hit8(addr_a[i], OFS_START_TIME) && lane_ok(addr_a[i]))
      begin
        full = {snap_start[i], s.next_first[7:0]};
        rb = full[{addr_a[i][2:0], 3'b000} +: 8];
      end
      else if (hit8(addr_a[i], OFS_NEXT_SECOND) && lane_ok(addr_a[i]))
      begin
        full = {snap_second[i], next_second_time[7:0]};
        rb = full[{addr_a[i][2:0], 3'b000} +: 8];
      end
      else if (hit4(addr_a[i], OFS_FIRST_PERIOD))
      begin
        rb = s.period[{addr_a[i][1:0], 3'b000} +: 8];
      end
      if (rd_a[i])
      begin
        next_s.rdata[i] = rb;
      end
    end

    // Host acknowledge of channel status registers
    if ((ack_by_write ? host_wr : host_rd) && host_addr == OFS_FIRST_ACK)
    begin
      next_s.event_req[0] = 1'b0;
      if (s.out_state == OUT_HELD)
      begin
        next_s.out_state = OUT_IDLE;
      end
    end
    if ((ack_by_write ? host_wr : host_rd) && host_addr == OFS_SECOND_ACK)
    begin
      next_s.event_req[1] = 1'b0;
      next_s.second_ack_clear = 1'b1;
    end

    // Start time completion: frame end or end of a host write burst
    if (|start_hit)
    begin
      next_s.start_pending = 1'b1;
    end
    commit = s.start_pending && (s.owner_host ? !(|start_hit) : frame_end);
    if (commit)
    begin
      if (s.act[ACT_EXTEND] && !next_s.upper_written && WIDE_TIME)
      begin
        next_s.start_stage[63:32] = system_time[63:32] +
          32'(next_s.start_stage[31:0] < system_time[31:0]);
      end
      next_s.start_pending = 1'b0;
      next_s.upper_written = 1'b0;
      if (s.act[ACT_AUTO] && !s.act[ACT_ENABLE])
      begin
        adopt = 1'b1;
      end
    end

    // Activation register write
    if (act_wr)
    begin
      next_s.act = act_new & 8'h7F;
      debug_fire = act_new[ACT_DEBUG];
      if (act_new[ACT_ENABLE] && !s.act[ACT_ENABLE])
      begin
        adopt = 1'b1;
      end
    end
    if (adopt)
    begin
      next_s.act[ACT_ENABLE] = 1'b1;
      next_s.next_first = next_s.start_stage;
      next_s.first_pending = 1'b1;
      next_s.single_done = 1'b0;
      diff = next_s.start_stage - system_time;
      next_s.plaus_out = diff >= (next_s.act[ACT_NEAR_SHORT] ?
        NEAR_SHORT : NEAR_LONG);
    end
    if (!next_s.act[ACT_ENABLE])
    begin
      next_s.first_pending = 1'b0;
    end

    // Pulse length timer
    case (s.out_state)
      OUT_IDLE:
      begin
        next_s.pulse_cnt = '0;
      end
      OUT_TIMED:
      begin
        if (s.pulse_cnt <= 17'h00001)
        begin
          next_s.out_state = OUT_IDLE;
          next_s.pulse_cnt = '0;
        end
        else
        begin
          next_s.pulse_cnt = s.pulse_cnt - 17'h00001;
        end
      end
      OUT_HELD:
      begin
        next_s.pulse_cnt = '0;
      end
      default:
      begin
        next_s.out_state = OUT_IDLE;
      end
    endcase

    // First channel scheduler
    immediate = s.first_pending && s.act[ACT_PLAUS] && s.plaus_out;
    reached = !system_time_before(system_time, s.next_first);
    fire = s.act[ACT_ENABLE] && s.act[ACT_GEN_FIRST] && !s.single_done &&
      !adopt && (immediate || reached);
    if (fire || (debug_fire && next_s.act[ACT_GEN_FIRST]))
    begin
      next_s.event_req[0] = 1'b1;
      if (pulse_width == 16'h0000)
      begin
        next_s.out_state = OUT_HELD;
      end
      else
      begin
        next_s.out_state = OUT_TIMED;
        next_s.pulse_cnt = width_cycles(pulse_width);
      end
    end
    if (fire)
    begin
      next_s.first_pending = 1'b0;
      if (s.period == PERIOD_RESET)
      begin
        next_s.single_done = 1'b1;
      end
      else
      begin
        next_s.next_first = s.next_first + 64'(s.period);
      end
    end

    // Second channel event request on its output rising edge
    if (second_sync_pulse && !s.second_prev)
    begin
      next_s.event_req[1] = 1'b1;
    end
    next_s.second_prev = second_sync_pulse;
    next_s.first_out = next_s.out_state != OUT_IDLE;
  end

  // True while time a lies before time b, modulo wrap
  function automatic logic system_time_before(input logic [63:0] a,
    input logic [63:0] b);
    logic [63:0] d;
    d = a - b;
    return d[63];
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.act <= ACT_RESET;
      s.start_stage <= TIME_RESET;
      s.next_first <= TIME_RESET;
      s.period <= PERIOD_RESET;
      s.out_state <= OUT_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign net_rdata = s.rdata[SIDE_NET];
  assign host_rdata = s.rdata[SIDE_HOST];
  assign first_sync_pulse = s.first_out;
  assign app_event_request = s.event_req;
  assign second_ack_clear = s.second_ack_clear;
  assign unit_active = s.act[ACT_ENABLE];
  assign second_gen_enable = s.act[ACT_GEN_SECOND];

endmodule // spss_sync_schedule
`default_nettype wire

// >>> verif/spss_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spss_host_model
  import spss_pkg::*;
(
  input wire logic clk, // clock
  output logic [15:0] host_addr, // byte address
  output logic host_rd, // read strobe
  output logic host_wr, // write strobe
  output logic [7:0] host_wdata, // write byte
  input wire logic [7:0] host_rdata // read byte
);
  initial
  begin
    host_addr = 16'hFFFF;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end

  // Bytes go out back to back so one commit sees the whole value
  task automatic wrn(input logic [15:0] a, input logic [63:0] d,
    input int nb);
    for (int i = 0; i < nb; i++)
    begin
      @(negedge clk);
      host_addr = a + 16'(i);
      host_wdata = d[8*i +: 8];
      host_wr = 1'b1;
    end
    @(negedge clk);
    host_wr = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    host_addr = ~a;
    d = host_rdata;
  endtask

  task automatic ack(input logic [15:0] a);
    wrn(a, 64'h0, 1);
  endtask
endmodule // spss_host_model
`default_nettype wire

// >>> verif/spss_sync_schedule_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spss_sync_schedule_monitor
  import spss_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [15:0] net_addr, // net address
  input wire logic net_rd, // net read
  input wire logic [7:0] net_rdata, // net data
  input wire logic [15:0] host_addr, // host address
  input wire logic host_rd, // host read
  input wire logic host_wr, // host write
  input wire logic [7:0] host_rdata, // host data
  input wire logic [15:0] pulse_width, // width
  input wire logic ack_by_write, // ack mode
  input wire logic [63:0] next_second_time, // second time
  input wire logic second_pending, // second pending
  input wire logic second_sync_pulse, // second output
  input wire logic first_sync_pulse, // first output
  input wire logic [1:0] app_event_request, // events
  input wire logic second_ack_clear // second ack
);
  logic ack1;
  logic [15:0] hi_cnt;
  logic [19:0] hi_exp;
  assign ack1 = host_addr == OFS_FIRST_ACK
    && (ack_by_write ? host_wr : host_rd);
  assign hi_exp = ({4'h0, pulse_width} * 20'hA + 20'h13) / 20'h14;
  always_ff @(posedge clk)
    hi_cnt <= (rst || !first_sync_pulse) ? 16'h0000 : hi_cnt + 16'h0001;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_ack2;
    host_addr == OFS_SECOND_ACK && (ack_by_write ? host_wr : host_rd);
  endsequence
  property p_ack2;
    s_ack2 |=> second_ack_clear;
  endproperty
  property p_wr_ign;
    host_wr && !host_rd && !ack_by_write && host_addr == OFS_SECOND_ACK
      |=> !second_ack_clear;
  endproperty
  property p_req0;
    app_event_request[0] && !ack1 |=> app_event_request[0];
  endproperty
  property p_hold;
    pulse_width == 16'h0000 && first_sync_pulse && !ack1
      |=> first_sync_pulse;
  endproperty
  property p_drop;
    pulse_width == 16'h0000 && first_sync_pulse && ack1
      |-> ##[1:2] !first_sync_pulse;
  endproperty
  property p_width;
    $fell(first_sync_pulse) && !$past(rst) && $past(pulse_width) != 16'h0
      |-> {4'h0, hi_cnt} == $past(hi_exp);
  endproperty
  property p_sts;
    host_rd && host_addr == OFS_ACT_STATE
      |=> host_rdata[1] == $past(second_pending);
  endproperty
  property p_s1;
    net_rd && net_addr == OFS_SECOND_ACK
      |=> net_rdata == {7'h00, $past(second_sync_pulse)};
  endproperty
  property p_nx2;
    host_rd && host_addr == OFS_NEXT_SECOND
      |=> {56'h0, host_rdata} == ($past(next_second_time) & 64'hFF);
  endproperty
  a_ack2: assert property (p_ack2) else $error("ack2 pulse missing");
  a_wr_ign: assert property (p_wr_ign) else $error("ack2 by write");
  a_req0: assert property (p_req0) else $error("event 0 lost");
  a_hold: assert property (p_hold) else $error("held output fell");
  a_drop: assert property (p_drop) else $error("held output stays");
  a_width: assert property (p_width) else $error("pulse length");
  a_sts: assert property (p_sts) else $error("second pending bit");
  a_s1: assert property (p_s1) else $error("second state byte");
  a_nx2: assert property (p_nx2) else $error("next second byte");
endmodule // spss_sync_schedule_monitor
bind spss_sync_schedule spss_sync_schedule_monitor i_mon (.clk, .rst,
  .net_addr, .net_rd, .net_rdata, .host_addr, .host_rd, .host_wr,
  .host_rdata, .pulse_width, .ack_by_write, .next_second_time,
  .second_pending, .second_sync_pulse, .first_sync_pulse,
  .app_event_request, .second_ack_clear);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import spss_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] net_addr = 16'h0000;
  logic net_rd = 1'b0;
  logic net_wr = 1'b0;
  logic [7:0] net_wdata = 8'h00;
  logic frame_end = 1'b0;
  logic [63:0] sys = 64'h0000_0005_FFFF_0000;
  logic [15:0] pwid = 16'h0005;
  logic abw = 1'b0;
  logic [63:0] nst = 64'h1122_3344_5566_7788;
  logic spend = 1'b0;
  logic s2 = 1'b0;
  logic [15:0] host_addr;
  logic host_rd, host_wr, fsp, s2clr, act, gen2;
  logic [7:0] host_wdata, host_rdata, net_rdata, b;
  logic [1:0] evt;
  logic [63:0] v, t, u;
  int err_total = 0;
  int compares = 0;
  int n;

  always #10 clk = ~clk;
  always @(negedge clk)
    sys <= sys + 64'h14;

  spss_host_model i_host (.clk, .host_addr, .host_rd, .host_wr,
    .host_wdata, .host_rdata);
  spss_sync_schedule i_spss_sync_schedule (.clk, .rst, .net_addr, .net_rd,
    .net_wr, .net_wdata, .net_rdata, .host_addr, .host_rd, .host_wr,
    .host_wdata, .host_rdata, .frame_end, .system_time(sys),
    .pulse_width(pwid), .ack_by_write(abw), .next_second_time(nst),
    .second_pending(spend), .second_sync_pulse(s2), .first_sync_pulse(fsp),
    .app_event_request(evt), .second_ack_clear(s2clr), .unit_active(act),
    .second_gen_enable(gen2));

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic nwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    net_addr = a;
    net_wdata = d;
    net_wr = 1'b1;
    @(negedge clk);
    net_wr = 1'b0;
    net_wdata = ~d;
  endtask

  task automatic nrd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    net_addr = a;
    net_rd = 1'b1;
    @(negedge clk);
    net_rd = 1'b0;
    d = net_rdata;
  endtask

  task automatic rd64(input logic h, input logic [15:0] a,
    output logic [63:0] r);
    for (int i = 0; i < 8; i++)
      if (h)
        i_host.rd(a + 16'(i), r[8*i +: 8]);
      else
        nrd(a + 16'(i), r[8*i +: 8]);
  endtask

  // Cycles until the next rising edge of the first output, 400 if none
  task automatic rise(output int c);
    logic lo;
    c = 0;
    lo = (fsp !== 1'b1);
    while (!(lo && fsp === 1'b1) && c < 400)
    begin
      @(negedge clk);
      c++;
      lo = lo | (fsp !== 1'b1);
    end
  endtask

  task automatic t_reset();
    rd64(1'b0, OFS_START_TIME, v);
    chk(v, TIME_RESET);
    nrd(OFS_ACT_STATE, b);
    chk(64'(b), 64'h0);
    nrd(OFS_PULSE_WIDTH, b);
    chk(64'(b), 64'(pwid[7:0]));
    nrd(OFS_SECOND_ACK, b);
    chk(64'(b), 64'h0);
    i_host.rd(16'h0A00, b);
    chk(64'(b), 64'h0);
    i_host.rd(OFS_NEXT_SECOND, b);
    t = nst;
    nst = 64'hA5A5_A5A5_A5A5_A5A5;
    for (int i = 1; i < 8; i++)
      i_host.rd(OFS_NEXT_SECOND + 16'(i), v[8*i +: 8]);
    chk({v[63:8], b}, t);
    rd64(1'b0, OFS_NEXT_SECOND, v);
    chk(v, nst);
    $display("t_reset done");
  endtask

  task automatic t_cyclic();
    nwr(OFS_OWNERSHIP, 8'h01);
    i_host.wrn(OFS_FIRST_PERIOD, 64'h7D0, 4);
    t = sys + 64'h7D0;
    i_host.wrn(OFS_START_TIME, t, 8);
    nwr(OFS_START_TIME, 8'hFF);
    @(negedge clk);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    i_host.wrn(OFS_ACTIVATION, 64'h03, 1);
    i_host.rd(OFS_ACT_STATE, b);
    chk(64'(b), 64'h01);
    rd64(1'b1, OFS_START_TIME, v);
    chk(v, t);
    i_host.wrn(OFS_START_TIME, 64'h0, 8);
    rise(n);
    chk(64'(sys - t < 64'h50), 64'h1);
    u = sys;
    i_host.rd(OFS_ACT_STATE, b);
    chk(64'(b), 64'h00);
    rd64(1'b0, OFS_START_TIME, v);
    chk(v, t + 64'h7D0);
    rise(n);
    chk(sys - u, 64'h7D0);
    repeat (5) @(negedge clk);
    i_host.wrn(OFS_ACTIVATION, 64'h00, 1);
    rise(n);
    chk(64'(n), 64'h190);
    $display("t_cyclic done");
  endtask

  task automatic t_single();
    i_host.wrn(OFS_FIRST_PERIOD, 64'h0, 4);
    t = sys + 64'h3E8;
    i_host.wrn(OFS_START_TIME, t, 8);
    i_host.wrn(OFS_ACTIVATION, 64'h07, 1);
    chk(64'(gen2), 64'h1);
    rise(n);
    chk(64'(n < 400), 64'h1);
    rise(n);
    chk(64'(n), 64'h190);
    // Debug bit gives one pulse even after the single shot
    i_host.wrn(OFS_ACTIVATION, 64'h87, 1);
    chk(64'(fsp), 64'h1);
    i_host.rd(OFS_ACTIVATION, b);
    chk(64'(b), 64'h07);
    i_host.wrn(OFS_ACTIVATION, 64'h00, 1);
    $display("t_single done");
  endtask

  task automatic t_auto();
    i_host.wrn(OFS_ACTIVATION, 64'h18, 1);
    chk(64'(act), 64'h0);
    t = sys + 64'h2_0000;
    i_host.wrn(OFS_START_TIME, t, 4);
    repeat (3) @(negedge clk);
    chk(64'(act), 64'h1);
    rd64(1'b1, OFS_START_TIME, v);
    chk(v, t);
    i_host.wrn(OFS_ACTIVATION, 64'h00, 1);
    $display("t_auto done");
  endtask

  task automatic t_ack();
    pwid = 16'h0000;
    i_host.wrn(OFS_ACTIVATION, 64'h62, 1);
    t = sys + 64'h1_0000_0000;
    i_host.wrn(OFS_START_TIME, t, 8);
    i_host.wrn(OFS_ACTIVATION, 64'h63, 1);
    rise(n);
    chk(64'(n < 8), 64'h1);
    i_host.rd(OFS_ACT_STATE, b);
    chk(64'(b), 64'h04);
    nrd(OFS_FIRST_ACK, b);
    chk(64'({fsp, evt[0], b}), 64'h301);
    i_host.rd(OFS_FIRST_ACK, b);
    repeat (2) @(negedge clk);
    chk(64'({fsp, evt[0], b}), 64'h001);
    spend = 1'b1;
    s2 = 1'b1;
    abw = 1'b1;
    repeat (3) @(negedge clk);
    i_host.rd(OFS_ACT_STATE, b);
    chk(64'(b[1]), 64'h1);
    i_host.rd(OFS_SECOND_ACK, b);
    chk(64'({evt[1], b}), 64'h101);
    i_host.ack(OFS_SECOND_ACK);
    @(negedge clk);
    chk(64'(evt[1]), 64'h0);
    abw = 1'b0;
    s2 = 1'b0;
    repeat (2) @(negedge clk);
    s2 = 1'b1;
    i_host.wrn(OFS_SECOND_ACK, 64'hFF, 1);
    chk(64'(evt[1]), 64'h1);
    i_host.rd(OFS_SECOND_ACK, b);
    @(negedge clk);
    chk(64'(evt[1]), 64'h0);
    $display("t_ack done");
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cyclic();
    t_single();
    t_auto();
    t_ack();
    end_sim();
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
